// *** core/watchdog_params.svh ***
`ifndef WATCHDOG_PARAMS_SVH
`define WATCHDOG_PARAMS_SVH

// ****************************************************************
// register map (byte addresses on the bus)
// ****************************************************************
`define WDG_GUARD_ADDR      8'hd8
`define WDG_STATUS_ADDR     8'hdc
`define WDG_GUARD_RESET     8'hfe

// ****************************************************************
// guard register field positions
// ****************************************************************
`define WDG_ACT_BIT         0
`define WDG_SR_BIT          1
`define WDG_CNT_LSB_BIT     7
`define WDG_CNT_MSB_BIT     2
`define WDG_CNT_RESET       7'h7f

// ****************************************************************
// status register field positions
// ****************************************************************
`define WDG_ST_ACTIVE_BIT   0
`define WDG_ST_HWOPT_BIT    1
`define WDG_ST_EXTHALT_BIT  2
`define WDG_ST_STOP_BIT     3
`define WDG_ST_WAIT_BIT     4
`define WDG_ST_NMI_BIT      5

// ****************************************************************
// timing
// ****************************************************************
`define WDG_CLK_PERIOD_NS   100
`define WDG_DECR_CYCLES     3072
`define WDG_PULSE_NS        500
`define WDG_PULSE_CYCLES    (`WDG_PULSE_NS / `WDG_CLK_PERIOD_NS)
`define WDG_STRAP_SETTLE    2

`endif

// *** core/watchdog_pkg.sv ***
`default_nettype none

package watchdog_pkg;

  // power state of the core as seen by the watchdog
  typedef enum logic [1:0] {
    pm_run,
    pm_wait,
    pm_stop
  } power_state_t;

  typedef logic [7:0]  bus_addr_t;
  typedef logic [31:0] bus_data_t;
  typedef logic [6:0]  guard_count_t;

endpackage

`default_nettype wire

// *** core/reset_pulse_gen.sv ***
`include "watchdog_params.svh"
`default_nettype none

module reset_pulse_gen (
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic fire,
  output var  logic reset_pin_n,
  output var  logic busy
);

  localparam logic [3:0] PULSE_LEN = 4'(`WDG_PULSE_CYCLES);

  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  logic       pin_n_nxt;
  logic       busy_nxt;

  // ****************************************************************
  // pulse length counter
  // ****************************************************************
  // a request while a pulse runs is merged into it
  always_comb begin
    cnt_nxt   = cnt_r;
    pin_n_nxt = 1'b1;
    busy_nxt  = 1'b0;
    if (cnt_r != 4'h0) begin
      cnt_nxt = cnt_r - 4'h1;
    end else if (fire) begin
      cnt_nxt = PULSE_LEN;
    end
    if (cnt_nxt != 4'h0) begin
      pin_n_nxt = 1'b0;
      busy_nxt  = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_r       <= 4'h0;
      reset_pin_n <= 1'b1;
      busy        <= 1'b0;
    end else begin
      cnt_r       <= cnt_nxt;
      reset_pin_n <= pin_n_nxt;
      busy        <= busy_nxt;
    end
  end

endmodule

`default_nettype wire

// *** core/watchdog_reset_timer.sv ***
// Summary of operation
// [RULE_01] hardware option: always active, bit stuck one
// [RULE_02] hardware option: activation bit read is meaningless
// [RULE_03] software option: off at reset, once on stays
// [RULE_04] counter decrements every 3072 clock cycles
// [RULE_05] timeout programmable in 64 decrement steps
// [RULE_06] active and soft reset bit zero: pulse reset
// [RULE_07] software refreshes with values FEh down to 02h
// [RULE_08] writing soft reset zero while active resets
// [RULE_09] software writes soft reset one, loads count
// [RULE_10] inactive software option: plain reversed 7-bit timer
// [RULE_11] timer reads should be done twice, compared
// [RULE_12] inactive: stop instruction enters stop mode
// [RULE_13] active without halt control: stop becomes wait
// [RULE_14] halt control: pin low wait, high stop frozen
// [RULE_15] interrupt leaves stop, counter resumes where frozen
// [RULE_16] activation bit0, soft reset bit1, count reversed
// [RULE_17] guard register at 0D8h, resets to FEh
// [RULE_18] inactive: soft reset bit is timer msb only
// [RULE_19] wait mode: counter keeps decrementing
// [RULE_20] no interrupt; only reset and readable count
//
// Design decisions made here: the address map and the Wishbone register port.
`include "watchdog_params.svh"
`default_nettype none

module watchdog_reset_timer (
  input  wire logic                   ref_clk,
  input  wire logic                   rst,
  input  wire logic                   wb_cyc_i,
  input  wire logic                   wb_stb_i,
  input  wire logic                   wb_we_i,
  input  wire watchdog_pkg::bus_addr_t wb_adr_i,
  input  wire logic [3:0]             wb_sel_i,
  input  wire watchdog_pkg::bus_data_t wb_dat_i,
  output var  watchdog_pkg::bus_data_t wb_dat_o,
  output var  logic                   wb_ack_o,
  input  wire logic                   guard_activation_option,
  input  wire logic                   external_halt_control,
  input  wire logic                   nmi_pin,
  input  wire logic                   stop_instr,
  input  wire logic                   wait_instr,
  input  wire logic                   wake_irq,
  output var  logic                   core_wait,
  output var  logic                   core_stop,
  output var  logic                   reset_pin_n
);

  import watchdog_pkg::*;

  localparam logic [11:0] DECR_LAST = 12'(`WDG_DECR_CYCLES - 1);
  // one extra cycle so the latch sees the second synchroniser flop filled
  localparam logic [1:0]  SETTLE    = 2'(`WDG_STRAP_SETTLE + 1);

  // ****************************************************************
  // declarations
  // ****************************************************************
  logic [1:0]   hwopt_sync_r;
  logic [1:0]   exthalt_sync_r;
  logic [1:0]   nmi_sync_r;
  logic [1:0]   settle_r;
  logic [1:0]   settle_nxt;
  logic         hwopt_r;
  logic         hwopt_nxt;
  logic         exthalt_r;
  logic         exthalt_nxt;

  logic         ack_r;
  logic         ack_nxt;
  bus_data_t    rdata_r;
  bus_data_t    rdata_nxt;
  logic         wr_guard;

  logic         act_r;
  logic         act_nxt;
  logic         act_eff;
  guard_count_t cnt_r;
  guard_count_t cnt_nxt;
  logic [11:0]  presc_r;
  logic [11:0]  presc_nxt;
  logic         tick;
  logic         fire_r;
  logic         fire_nxt;
  logic         pulse_busy;
  logic [7:0]   guard_view;

  power_state_t pm_r;
  power_state_t pm_nxt;
  logic         wait_nxt;
  logic         stop_nxt;

  // ****************************************************************
  // pin synchronisers and option straps
  // ****************************************************************
  // straps and the nmi pin come from outside; two flops before use
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      hwopt_sync_r   <= 2'h0;
      exthalt_sync_r <= 2'h0;
      nmi_sync_r     <= 2'h0;
    end else begin
      hwopt_sync_r   <= {hwopt_sync_r[0], guard_activation_option};
      exthalt_sync_r <= {exthalt_sync_r[0], external_halt_control};
      nmi_sync_r     <= {nmi_sync_r[0], nmi_pin};
    end
  end

  // straps are caught once, after the synchronisers have filled
  always_comb begin
    settle_nxt  = settle_r;
    hwopt_nxt   = hwopt_r;
    exthalt_nxt = exthalt_r;
    if (settle_r != SETTLE) begin
      settle_nxt  = settle_r + 2'h1;
      hwopt_nxt   = hwopt_sync_r[1];
      exthalt_nxt = exthalt_sync_r[1];
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      settle_r  <= 2'h0;
      hwopt_r   <= 1'b0;
      exthalt_r <= 1'b0;
    end else begin
      settle_r  <= settle_nxt;
      hwopt_r   <= hwopt_nxt;
      exthalt_r <= exthalt_nxt;
    end
  end

  // ****************************************************************
  // wishbone slave
  // ****************************************************************
  // ack one cycle after the request; a write lands on the ack edge
  assign wr_guard = wb_cyc_i && wb_stb_i && wb_we_i && ack_r && wb_sel_i[0]
                    && (wb_adr_i == `WDG_GUARD_ADDR);

  // count bits shown reversed next to soft reset and activation
  always_comb begin
    guard_view = 8'h00;
    guard_view[`WDG_ACT_BIT] = act_eff;                                 // [RULE_02]
    guard_view[`WDG_SR_BIT]  = cnt_r[6];                                // [RULE_16]
    for (int i = 0; i < 6; i++) begin
      guard_view[`WDG_CNT_LSB_BIT - i] = cnt_r[i];                      // [RULE_16] [RULE_10]
    end
  end

  always_comb begin
    ack_nxt   = 1'b0;
    rdata_nxt = rdata_r;
    if (wb_cyc_i && wb_stb_i && !ack_r) begin
      ack_nxt   = 1'b1;
      rdata_nxt = 32'h0000_0000;
      if (wb_adr_i == `WDG_GUARD_ADDR) begin
        rdata_nxt[7:0] = guard_view;                                    // [RULE_17] [RULE_20]
      end else if (wb_adr_i == `WDG_STATUS_ADDR) begin
        rdata_nxt[`WDG_ST_ACTIVE_BIT]  = act_eff;
        rdata_nxt[`WDG_ST_HWOPT_BIT]   = hwopt_r;
        rdata_nxt[`WDG_ST_EXTHALT_BIT] = exthalt_r;
        rdata_nxt[`WDG_ST_STOP_BIT]    = core_stop;
        rdata_nxt[`WDG_ST_WAIT_BIT]    = core_wait;
        rdata_nxt[`WDG_ST_NMI_BIT]     = nmi_sync_r[1];
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ack_r   <= 1'b0;
      rdata_r <= 32'h0000_0000;
    end else begin
      ack_r   <= ack_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdata_r;

  // ****************************************************************
  // activation, prescaler and downcounter
  // ****************************************************************
  // hardware option forces the watchdog on regardless of the bit
  assign act_eff = act_r || hwopt_r;                                    // [RULE_01]
  // decrement clock is frozen while the core is stopped
  assign tick    = (presc_r == DECR_LAST) && (pm_r != pm_stop);         // [RULE_04] [RULE_14]

  always_comb begin
    act_nxt   = act_r;
    cnt_nxt   = cnt_r;
    presc_nxt = presc_r;
    fire_nxt  = 1'b0;
    // prescaler holds in stop, resumes on wake from the same value
    if (pm_r != pm_stop) begin                                          // [RULE_15] [RULE_19]
      presc_nxt = (presc_r == DECR_LAST) ? 12'h000 : presc_r + 12'h001; // [RULE_04]
    end
    if (tick) begin
      cnt_nxt = cnt_r - 7'h01;                                          // [RULE_05] [RULE_10]
    end
    // a write wins over a coinciding decrement
    if (wr_guard) begin
      // once set, only a device reset or the block's own reset pulse (fire_r) clears the activation bit
      act_nxt = act_r || wb_dat_i[`WDG_ACT_BIT] || hwopt_r;             // [RULE_03] [RULE_01]
      cnt_nxt[6] = wb_dat_i[`WDG_SR_BIT];                               // [RULE_16]
      for (int i = 0; i < 6; i++) begin
        cnt_nxt[i] = wb_dat_i[`WDG_CNT_LSB_BIT - i];                    // [RULE_16]
      end
    end
    // soft reset bit low while active: a written zero fires at once
    if ((act_nxt || hwopt_r) && !cnt_nxt[6] && !pulse_busy) begin       // [RULE_06] [RULE_08] [RULE_18]
      fire_nxt = 1'b1;
    end
    // the reset pulse returns the block to its reset state
    if (fire_r) begin
      act_nxt   = 1'b0;
      cnt_nxt   = `WDG_CNT_RESET;
      presc_nxt = 12'h000;
      fire_nxt  = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      act_r   <= 1'b0;
      cnt_r   <= `WDG_CNT_RESET;                                        // [RULE_17] [RULE_03]
      presc_r <= 12'h000;
      fire_r  <= 1'b0;
    end else begin
      act_r   <= act_nxt;
      cnt_r   <= cnt_nxt;
      presc_r <= presc_nxt;
      fire_r  <= fire_nxt;
    end
  end

  // ****************************************************************
  // reset pin pulse
  // ****************************************************************
  reset_pulse_gen u_pulse (
    .ref_clk     (ref_clk),
    .rst         (rst),
    .fire        (fire_r),                                              // [RULE_06]
    .reset_pin_n (reset_pin_n),
    .busy        (pulse_busy)
  );

  // ****************************************************************
  // low power handling
  // ****************************************************************
  // stop is honoured, turned into wait, or split on the nmi level
  always_comb begin
    pm_nxt = pm_r;
    case (pm_r)
      pm_run: begin
        if (stop_instr) begin
          if (!act_eff) begin
            pm_nxt = pm_stop;                                           // [RULE_12]
          end else if (!exthalt_r) begin
            pm_nxt = pm_wait;                                           // [RULE_13]
          end else if (nmi_sync_r[1]) begin
            pm_nxt = pm_stop;                                           // [RULE_14]
          end else begin
            pm_nxt = pm_wait;                                           // [RULE_14]
          end
        end else if (wait_instr) begin
          pm_nxt = pm_wait;                                             // [RULE_19]
        end
      end
      pm_wait: begin
        if (wake_irq) begin
          pm_nxt = pm_run;
        end
      end
      pm_stop: begin
        if (wake_irq) begin
          pm_nxt = pm_run;                                              // [RULE_15]
        end
      end
      default: begin
        pm_nxt = pm_run;
      end
    endcase
    if (fire_r) begin
      pm_nxt = pm_run;
    end
    wait_nxt = (pm_nxt == pm_wait);
    stop_nxt = (pm_nxt == pm_stop);
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pm_r      <= pm_run;
      core_wait <= 1'b0;
      core_stop <= 1'b0;
    end else begin
      pm_r      <= pm_nxt;
      core_wait <= wait_nxt;
      core_stop <= stop_nxt;
    end
  end

endmodule

`default_nettype wire

// *** dv/watchdog_chk.sv ***
`include "watchdog_params.svh"
`default_nettype none

// ****************************************
// port checker for the guard timer
// ****************************************
module watchdog_chk (
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        guard_activation_option,
  input wire logic        external_halt_control,
  input wire logic        nmi_pin,
  input wire logic        stop_instr,
  input wire logic        wait_instr,
  input wire logic        wake_irq,
  input wire logic        core_wait,
  input wire logic        core_stop,
  input wire logic        reset_pin_n
);
  timeunit 1ns;
  timeprecision 1ns;

  // hardware option forces the guard on
  wire logic hw;
  wire logic run;
  assign hw = guard_activation_option;
  assign run = !core_wait && !core_stop;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  // request steps
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_sr_clear;
    wb_ack_o && wb_stb_i && wb_we_i && wb_sel_i[0] && wb_adr_i == `WDG_GUARD_ADDR && wb_dat_i[1:0] == 2'b01;
  endsequence
  sequence s_nmi_stop;
    nmi_pin [*3] ##0 (hw && external_halt_control && stop_instr && !wake_irq && run);
  endsequence

  a_ack_one: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
  a_ack_answer: assert property (s_req |=> wb_ack_o) else $error("no ack");
  a_dat_upper: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0) else $error("upper bits set");
  a_hw_act_bit: assert property (
    hw && wb_ack_o && !wb_we_i && wb_adr_i == `WDG_GUARD_ADDR |-> wb_dat_o[0]) else $error("act bit low");
  a_sw_reset: assert property (s_sr_clear |-> ##[2:3] !reset_pin_n) else $error("no soft reset");
  a_pulse_width: assert property (
    $fell(reset_pin_n) |-> (!reset_pin_n) [*5] ##1 reset_pin_n) else $error("pulse width");
  a_stop_as_wait: assert property (
    hw && !external_halt_control && stop_instr && !wake_irq && run |=> core_wait && !core_stop)
    else $error("stop not wait");
  a_nmi_stop: assert property (s_nmi_stop |=> core_stop && !core_wait) else $error("no stop");
  a_modes_excl: assert property (!(core_stop && core_wait)) else $error("wait and stop");
  a_wake_run: assert property (
    wake_irq && !stop_instr && !wait_instr |=> run) else $error("no wake");
  a_wait_enter: assert property (
    wait_instr && !wake_irq && !stop_instr && !core_stop |=> core_wait) else $error("no wait");
endmodule

bind watchdog_reset_timer watchdog_chk chk (
  .ref_clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
  .guard_activation_option, .external_halt_control, .nmi_pin, .stop_instr, .wait_instr, .wake_irq,
  .core_wait, .core_stop, .reset_pin_n
);

`default_nettype wire

// *** dv/soft_host.sv ***
`default_nettype none

// ****************************************
// software side: bus master and nmi line
// ****************************************
module soft_host (
  input  wire logic        ref_clk,
  input  wire logic        wb_ack_o,
  output var  logic        wb_cyc_i,
  output var  logic        wb_stb_i,
  output var  logic        wb_we_i,
  output var  logic [7:0]  wb_adr_i,
  output var  logic [3:0]  wb_sel_i,
  output var  logic [31:0] wb_dat_i,
  output var  logic        nmi_pin
);
  timeunit 1ns;
  timeprecision 1ns;

  // idle bus, nmi low
  initial begin
    {wb_cyc_i, wb_stb_i, wb_we_i, nmi_pin} = 4'h0;
    wb_sel_i = 4'h1;
    wb_adr_i = 8'h00;
    wb_dat_i = 32'h0;
  end

  // one classic cycle; released lines show the inverse
  task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge ref_clk);
    {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, we};
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= s;
    do @(posedge ref_clk); while (wb_ack_o !== 1'b1);
    {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b00, ~we};
    wb_adr_i <= ~a;
    wb_dat_i <= ~d;
    wb_sel_i <= ~s;
  endtask

  // nmi level, given time to pass the synchroniser
  task automatic set_nmi(input logic v);
    @(posedge ref_clk);
    nmi_pin <= v;
    repeat (4) @(posedge ref_clk);
  endtask
endmodule

`default_nettype wire

// *** dv/watchdog_reset_timer_tb_top.sv ***
`include "watchdog_params.svh"
`default_nettype none

// ****************************************
// bench for the guard timer
// ****************************************
module watchdog_reset_timer_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import watchdog_pkg::*;
  logic       ref_clk = 1'b0;
  logic       rst = 1'b1;
  logic       hw_opt = 1'b0;
  logic       halt_opt = 1'b0;
  logic       stop_instr = 1'b0;
  logic       wait_instr = 1'b0;
  logic       wake_irq = 1'b0;
  logic       wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, nmi_pin;
  logic       core_wait, core_stop, reset_pin_n;
  logic [3:0] wb_sel_i;
  bus_addr_t  wb_adr_i;
  bus_data_t  wb_dat_i, wb_dat_o;
  bus_data_t  exp_q[$];
  int         n_errors = 0;
  int         n_tests = 0;
  logic [5:0] c;

  watchdog_reset_timer uut (
    .ref_clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
    .guard_activation_option(hw_opt), .external_halt_control(halt_opt), .nmi_pin, .stop_instr,
    .wait_instr, .wake_irq, .core_wait, .core_stop, .reset_pin_n
  );
  soft_host host (
    .ref_clk, .wb_ack_o, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .nmi_pin
  );

  // 10 MHz clock
  always #50 ref_clk = ~ref_clk;

  task automatic conclude();
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic check(input bus_data_t seen, input bus_data_t exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // count field is stored bit-reversed
  function automatic logic [5:0] rev6(input logic [5:0] v);
    for (int i = 0; i < 6; i++) rev6[i] = v[5 - i];
  endfunction

  task automatic wr(input bus_data_t d);
    host.xfer(1'b1, `WDG_GUARD_ADDR, d, 4'h1);
  endtask

  task automatic rd(input bus_addr_t a, input bus_data_t e);
    exp_q.push_back(e);
    host.xfer(1'b0, a, 32'h0, 4'h1);
  endtask

  // straps only change while reset is held
  task automatic boot(input logic hw, input logic halt);
    @(posedge ref_clk);
    rst <= 1'b1;
    hw_opt <= hw;
    halt_opt <= halt;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (4) @(posedge ref_clk);
  endtask

  // pulse {stop, wait, wake}, then check {stop, wait}
  task automatic lp(input logic [2:0] v, input logic [1:0] e);
    @(posedge ref_clk);
    {stop_instr, wait_instr, wake_irq} <= v;
    @(posedge ref_clk);
    {stop_instr, wait_instr, wake_irq} <= 3'b000;
    @(negedge ref_clk);
    check({30'h0, core_stop, core_wait}, {30'h0, e});
  endtask

  // reset pin must fall within lim cycles and be high again five cycles later
  task automatic expect_pulse(input int lim);
    int n;
    n = 0;
    while (reset_pin_n !== 1'b0 && n < lim) begin
      @(negedge ref_clk);
      n++;
    end
    check({31'h0, reset_pin_n}, 32'h0);
    repeat (5) @(negedge ref_clk);
    check({31'h0, reset_pin_n}, 32'h1);
  endtask

  // read data checked against the oldest note
  always @(posedge ref_clk) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) check(wb_dat_o, exp_q.pop_front());
  end

  // hang guard
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_errors++;
    conclude();
  end

  // reads spaced 3072 cycles apart see exactly one decrement while running and none while stopped
  initial begin
    void'($urandom(99672));
    boot(1'b0, 1'b0);
    rd(`WDG_GUARD_ADDR, 32'hfe);
    host.xfer(1'b1, 8'hc0, 32'h5a, 4'h1);
    rd(8'hc0, 32'h0);
    // a write without byte lane 0 must not touch the guard
    host.xfer(1'b1, `WDG_GUARD_ADDR, 32'h01, 4'he);
    rd(`WDG_GUARD_ADDR, 32'hfe);
    lp(3'b100, 2'b10);
    lp(3'b001, 2'b00);
    lp(3'b010, 2'b01);
    lp(3'b001, 2'b00);
    c = 6'($urandom_range(63, 1));
    wr({24'h0, rev6(c), 2'b00});
    repeat (4) @(negedge ref_clk);
    check({31'h0, reset_pin_n}, 32'h1);
    wr({24'h0, rev6(c), 2'b10});
    rd(`WDG_GUARD_ADDR, {24'h0, rev6(c), 2'b10});
    rd(`WDG_GUARD_ADDR, {24'h0, rev6(c), 2'b10});
    repeat (3069) @(posedge ref_clk);
    rd(`WDG_GUARD_ADDR, {24'h0, rev6(c - 6'h1), 2'b10});
    wr(32'hfb);
    wr(32'hfa);
    rd(`WDG_GUARD_ADDR, 32'hfb);
    wr(32'h01);
    expect_pulse(8);
    rd(`WDG_GUARD_ADDR, 32'hfe);
    wr(32'h03);
    lp(3'b010, 2'b01);
    expect_pulse(3080);
    boot(1'b1, 1'b1);
    rd(`WDG_GUARD_ADDR, 32'hff);
    wr(32'hfe);
    rd(`WDG_GUARD_ADDR, 32'hff);
    lp(3'b100, 2'b01);
    lp(3'b001, 2'b00);
    host.set_nmi(1'b1);
    lp(3'b100, 2'b10);
    rd(`WDG_GUARD_ADDR, 32'hff);
    // status: active, hardware option, halt control, stop, nmi high
    rd(`WDG_STATUS_ADDR, 32'h2f);
    repeat (3069) @(posedge ref_clk);
    rd(`WDG_GUARD_ADDR, 32'hff);
    lp(3'b001, 2'b00);
    boot(1'b1, 1'b0);
    lp(3'b100, 2'b01);
    conclude();
  end
endmodule

`default_nettype wire
